// ==== verilog/ptw_pkg.sv ====
package ptw_pkg;

    // ************************************************************
    // Register map (byte addresses on the AXI4-Lite slave)
    // ************************************************************
    localparam logic [5:0] OFS_TIM      = 6'h00;
    localparam logic [5:0] OFS_PRD      = 6'h04;
    localparam logic [5:0] OFS_TCR      = 6'h08;
    localparam logic [5:0] OFS_TIMER_PRESCALE_MODE_CONTROL     = 6'h0C;
    localparam logic [5:0] OFS_WD_TIM   = 6'h10;
    localparam logic [5:0] OFS_WD_PRD   = 6'h14;
    localparam logic [5:0] OFS_WD_TCR   = 6'h18;
    localparam logic [5:0] OFS_WD_TIMER_PRESCALE_MODE_CONTROL  = 6'h1C;
    localparam logic [5:0] OFS_WD_KEY   = 6'h20;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POS_SOFT  = 11;
    localparam int POS_FREE  = 10;
    localparam int POS_PSC   = 6;
    localparam int POS_TRB   = 5;
    localparam int POS_TSS   = 4;
    localparam int POS_PRESCALE_MODE_SELECT = 12;
    localparam int POS_WDEN  = 1;
    localparam int POS_WDFLG = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] RST_COUNT    = 16'hFFFF;
    localparam logic [3:0]  RST_PRESCALE_RELOAD_FIELD     = 4'h0;
    localparam logic [3:0]  RST_WD_PRESCALE_RELOAD_FIELD  = 4'hF;

    // ************************************************************
    // Watchdog keys and output pulse (key values arbitrary)
    // ************************************************************
    localparam logic [15:0] KEY_EN_A     = 16'h5A5A;
    localparam logic [15:0] KEY_EN_B     = 16'hA5A5;
    localparam logic [15:0] KEY_SVC_A    = 16'h3C3C;
    localparam logic [15:0] KEY_SVC_B    = 16'hC3C3;
    localparam int          CLK_NS       = 50;
    localparam int          WD_PULSE_NS  = 100;
    localparam logic [3:0]  WD_PULSE_CYC =
        4'((WD_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic        WD_PULSE_LVL = 1'b0;

    // ************************************************************
    // AXI responses
    // ************************************************************
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Prescaler configuration carrier
    typedef struct packed {
        logic       prescale_mode_select;
        logic [3:0] field;
    } ptw_pre_cfg_s;

    // Key detector states
    typedef enum logic {KS_IDLE, KS_GOT_A} ptw_key_e;

endpackage

// ==== verilog/ptw_prescaler.sv ====
`timescale 1ns/1ns
`default_nettype none
module ptw_prescaler
    import ptw_pkg::*;
(
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire ptw_pre_cfg_s cfg,
    input  wire logic         run,
    input  wire logic         reload,
    // Status
    output logic              tick,
    output logic [15:0]       count
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [16:0] ind_val;
    logic [15:0] reload_val;

    // Direct field or indirect 2^(n+1)-1 table
    assign ind_val    = (17'h00001 << ({1'b0, cfg.field} + 5'h01)) - 17'h00001;
    assign reload_val = cfg.prescale_mode_select ? ind_val[15:0] : {12'h000, cfg.field};
    assign tick       = run && (cnt_ff == 16'h0000);
    assign count      = cnt_ff;
    assign nxt_cnt    = (reload || tick) ? reload_val :
                        (run ? cnt_ff - 16'h0001 : cnt_ff);

    // One decrement per clock while running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    a_direct_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !cfg.prescale_mode_select && !reload |=> cnt_ff == {12'h000, $past(cfg.field)})
        else $error("direct prescale reload wrong");
endmodule
`default_nettype wire

// ==== verilog/ptw_keyseq.sv ====
`timescale 1ns/1ns
`default_nettype none
module ptw_keyseq
    import ptw_pkg::*;
#(
    parameter logic [15:0] KEY_A = 16'h0000,
    parameter logic [15:0] KEY_B = 16'h0000
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Key writes
    input  wire logic        wr,
    input  wire logic [15:0] data,
    // Sequence complete
    output logic             hit
);
    ptw_key_e state_ff;
    ptw_key_e nxt_state;
    logic     hit_ff;
    logic     nxt_hit;

    // Any off-sequence write other than KEY_A drops back, so stray writes never match
    always_comb begin
        nxt_state = state_ff;
        nxt_hit   = 1'b0;
        if (wr) begin
            case (state_ff)
                KS_IDLE: begin
                    nxt_state = (data == KEY_A) ? KS_GOT_A : KS_IDLE;
                end
                KS_GOT_A: begin
                    nxt_hit   = (data == KEY_B);
                    nxt_state = (data == KEY_A) ? KS_GOT_A : KS_IDLE;
                end
                default: begin
                    nxt_state = KS_IDLE;
                end
            endcase
        end
    end

    // State and one-cycle hit pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= KS_IDLE;
            hit_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hit_ff   <= nxt_hit;
        end
    end

    assign hit = hit_ff;
endmodule
`default_nettype wire

// ==== verilog/ptw_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module ptw_top
    import ptw_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // General-purpose drive of the shared pin
    input  wire logic        gpio_pin_o,
    input  wire logic        gpio_pin_oe,
    // Shared pin and events
    output logic             shared_pin_o,
    output logic             shared_pin_oe,
    output logic             timer_irq,
    output logic             watchdog_timeout_irq
);
    // ************************************************************
    // Bus slave
    // ************************************************************
    logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic        aw_have_ff, w_have_ff;
    logic [5:0]  awaddr_ff;
    logic [15:0] wdata_ff;
    logic [1:0]  wstrb_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic        aw_take, w_take, ar_take, wr_go;
    logic        nxt_aw_have, nxt_w_have, nxt_rvalid;

    assign aw_take     = s_axi_awvalid && awready_ff;
    assign w_take      = s_axi_wvalid && wready_ff;
    assign ar_take     = s_axi_arvalid && arready_ff;
    assign wr_go       = aw_have_ff && w_have_ff && !bvalid_ff;
    assign nxt_aw_have = aw_have_ff ? !wr_go : aw_take;
    assign nxt_w_have  = w_have_ff ? !wr_go : w_take;
    assign nxt_rvalid  = ar_take || (rvalid_ff && !s_axi_rready);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [15:0] tim_ff, prd_ff, wd_tim_ff, wd_prd_ff;
    logic [3:0]  prescale_reload_field_ff, wd_prescale_reload_field_ff;
    logic        tss_ff, soft_ff, free_ff, prescale_mode_select_ff;
    logic        wd_soft_ff, wd_free_ff, wd_prescale_mode_select_ff;
    logic        wd_en_ff, wd_flag_ff, tirq_ff, wdirq_ff;
    logic [3:0]  pulse_ff;
    logic        pin_o_ff, pin_oe_ff;

    // Write decode; a lane only counts when its strobe is set
    logic [15:0] wmask, tim_wr_val;
    logic        sel_tim, sel_prd, sel_tcr, sel_timer_prescale_mode_control;
    logic        sel_wdprd, sel_wdtcr, sel_wdtscr, sel_key, wr_ok;
    assign wmask      = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign sel_tim    = wr_go && (awaddr_ff == OFS_TIM);
    assign sel_prd    = wr_go && (awaddr_ff == OFS_PRD);
    assign sel_tcr    = wr_go && (awaddr_ff == OFS_TCR);
    assign sel_timer_prescale_mode_control   = wr_go && (awaddr_ff == OFS_TIMER_PRESCALE_MODE_CONTROL);
    assign sel_wdprd  = wr_go && (awaddr_ff == OFS_WD_PRD);
    assign sel_wdtcr  = wr_go && (awaddr_ff == OFS_WD_TCR);
    assign sel_wdtscr = wr_go && (awaddr_ff == OFS_WD_TIMER_PRESCALE_MODE_CONTROL);
    assign sel_key    = wr_go && (awaddr_ff == OFS_WD_KEY) && (wstrb_ff == 2'b11);
    assign wr_ok      = sel_tim || sel_prd || sel_tcr || sel_timer_prescale_mode_control || sel_wdprd ||
                        sel_wdtcr || sel_wdtscr || (awaddr_ff == OFS_WD_TIM) ||
                        (awaddr_ff == OFS_WD_KEY);
    assign tim_wr_val = (tim_ff & ~wmask) | (wdata_ff & wmask);

    // ************************************************************
    // Prescalers and key detectors
    // ************************************************************
    ptw_pre_cfg_s tcfg, wcfg;
    logic         t_tick, w_tick, trb_pulse, svc_hit, en_hit, wd_tmo, t_zero;
    logic [15:0]  t_psc, w_psc;
    assign tcfg      = '{prescale_mode_select: prescale_mode_select_ff, field: prescale_reload_field_ff};
    assign wcfg      = '{prescale_mode_select: wd_prescale_mode_select_ff, field: wd_prescale_reload_field_ff};
    assign trb_pulse = sel_tcr && wstrb_ff[0] && wdata_ff[POS_TRB];
    assign wd_tmo    = w_tick && (wd_tim_ff == 16'h0000);
    assign t_zero    = t_tick && (tim_ff == 16'h0000);

    ptw_prescaler u_tpre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cfg     (tcfg),
        .run     (!tss_ff),
        .reload  (trb_pulse),
        .tick    (t_tick),
        .count   (t_psc)
    );

    // Watchdog prescaler never stops; reloads on time-out and service
    ptw_prescaler u_wpre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cfg     (wcfg),
        .run     (1'b1),
        .reload  (svc_hit || wd_tmo),
        .tick    (w_tick),
        .count   (w_psc)
    );

    ptw_keyseq #(.KEY_A(KEY_EN_A), .KEY_B(KEY_EN_B)) u_enkey (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr      (sel_key),
        .data    (wdata_ff),
        .hit     (en_hit)
    );

    ptw_keyseq #(.KEY_A(KEY_SVC_A), .KEY_B(KEY_SVC_B)) u_svkey (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr      (sel_key),
        .data    (wdata_ff),
        .hit     (svc_hit)
    );

    // ************************************************************
    // Read mux
    // ************************************************************
    logic [15:0] rd_val;
    logic        rd_ok;
    always_comb begin
        rd_val = 16'h0000;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            OFS_TIM:     rd_val = tim_ff;
            OFS_PRD:     rd_val = prd_ff;
            OFS_TCR:     rd_val = {4'h0, soft_ff, free_ff, t_psc[3:0], 1'b0, tss_ff, prescale_reload_field_ff};
            OFS_TIMER_PRESCALE_MODE_CONTROL:    rd_val = 16'(prescale_mode_select_ff) << POS_PRESCALE_MODE_SELECT;
            OFS_WD_TIM:  rd_val = wd_tim_ff;
            OFS_WD_PRD:  rd_val = wd_prd_ff;
            OFS_WD_TCR:  rd_val = {4'h0, wd_soft_ff, wd_free_ff, w_psc[3:0], 2'b00, wd_prescale_reload_field_ff};
            OFS_WD_TIMER_PRESCALE_MODE_CONTROL: rd_val = (16'(wd_prescale_mode_select_ff) << POS_PRESCALE_MODE_SELECT) |
                                  (16'(wd_en_ff) << POS_WDEN) | 16'(wd_flag_ff);
            OFS_WD_KEY:  rd_val = 16'h0000;
            default:     rd_ok  = 1'b0;
        endcase
    end

    // ************************************************************
    // Bus handshakes
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= 32'h00000000;
            awaddr_ff  <= 6'h00;
            wdata_ff   <= 16'h0000;
            wstrb_ff   <= 2'b00;
        end else begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff  <= nxt_w_have;
            awready_ff <= !nxt_aw_have;
            wready_ff  <= !nxt_w_have;
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (aw_take) awaddr_ff <= s_axi_awaddr;
            if (w_take) begin
                wdata_ff <= s_axi_wdata[15:0];
                wstrb_ff <= s_axi_wstrb[1:0];
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (ar_take) begin
                rdata_ff <= {16'h0000, rd_val};
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ************************************************************
    // General timer
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tim_ff   <= RST_COUNT;
            prd_ff   <= RST_COUNT;
            prescale_reload_field_ff  <= RST_PRESCALE_RELOAD_FIELD;
            prescale_mode_select_ff <= 1'b0;
            tss_ff   <= 1'b0;
            soft_ff  <= 1'b0;
            free_ff  <= 1'b0;
            tirq_ff  <= 1'b0;
        end else begin
            tirq_ff <= t_zero;
            if (sel_tim) begin
                tim_ff <= tim_wr_val;
            end else if (trb_pulse || t_zero) begin
                tim_ff <= prd_ff;
            end else if (t_tick) begin
                tim_ff <= tim_ff - 16'h0001;
            end
            if (sel_prd) prd_ff <= (prd_ff & ~wmask) | (wdata_ff & wmask);
            if (sel_tcr && wstrb_ff[0]) begin
                prescale_reload_field_ff <= wdata_ff[3:0];
                tss_ff  <= wdata_ff[POS_TSS];
            end
            if (sel_tcr && wstrb_ff[1]) begin
                soft_ff <= wdata_ff[POS_SOFT];
                free_ff <= wdata_ff[POS_FREE];
            end
            // Only bit 12 is stored; reserved bits have no flop
            if (sel_timer_prescale_mode_control && wstrb_ff[1]) prescale_mode_select_ff <= wdata_ff[POS_PRESCALE_MODE_SELECT];
        end
    end

    // ************************************************************
    // Watchdog counter and control
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_tim_ff   <= RST_COUNT;
            wd_prd_ff   <= RST_COUNT;
            wd_prescale_reload_field_ff  <= RST_WD_PRESCALE_RELOAD_FIELD;
            wd_prescale_mode_select_ff <= 1'b0;
            wd_soft_ff  <= 1'b0;
            wd_free_ff  <= 1'b0;
            wd_en_ff    <= 1'b0;
            wd_flag_ff  <= 1'b0;
            wdirq_ff    <= 1'b0;
        end else begin
            wdirq_ff <= wd_tmo;
            // Time-out and service both restart from the period
            if (wd_tmo || svc_hit) begin
                wd_tim_ff <= wd_prd_ff;
            end else if (w_tick) begin
                wd_tim_ff <= wd_tim_ff - 16'h0001;
            end
            if (sel_wdprd) wd_prd_ff <= (wd_prd_ff & ~wmask) | (wdata_ff & wmask);
            if (sel_wdtcr && wstrb_ff[0]) wd_prescale_reload_field_ff <= wdata_ff[3:0];
            if (sel_wdtcr && wstrb_ff[1]) begin
                wd_soft_ff <= wdata_ff[POS_SOFT];
                wd_free_ff <= wdata_ff[POS_FREE];
            end
            if (sel_wdtscr && wstrb_ff[1]) wd_prescale_mode_select_ff <= wdata_ff[POS_PRESCALE_MODE_SELECT];
            // Time-out drops enable; no write path clears it
            if (wd_tmo) begin
                wd_en_ff <= 1'b0;
            end else if (en_hit) begin
                wd_en_ff <= 1'b1;
            end
            // Set wins over a write-one clear in the same cycle
            if (wd_tmo) begin
                wd_flag_ff <= 1'b1;
            end else if (sel_wdtscr && wstrb_ff[0] && wdata_ff[POS_WDFLG]) begin
                wd_flag_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Shared pin: gpio drive, or watchdog while enabled or pulsing
    // ************************************************************
    logic wd_owns;
    assign wd_owns = wd_en_ff || (pulse_ff != 4'h0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_ff  <= 4'h0;
            pin_o_ff  <= 1'b1;
            pin_oe_ff <= 1'b0;
        end else begin
            if (wd_tmo && wd_en_ff) begin
                pulse_ff <= WD_PULSE_CYC;
            end else if (pulse_ff != 4'h0) begin
                pulse_ff <= pulse_ff - 4'h1;
            end
            pin_oe_ff <= wd_owns ? 1'b1 : gpio_pin_oe;
            pin_o_ff  <= !wd_owns ? gpio_pin_o :
                         ((pulse_ff != 4'h0) ? WD_PULSE_LVL : !WD_PULSE_LVL);
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready        = awready_ff;
    assign s_axi_wready         = wready_ff;
    assign s_axi_bvalid         = bvalid_ff;
    assign s_axi_bresp          = bresp_ff;
    assign s_axi_arready        = arready_ff;
    assign s_axi_rvalid         = rvalid_ff;
    assign s_axi_rresp          = rresp_ff;
    assign s_axi_rdata          = rdata_ff;
    assign shared_pin_o         = pin_o_ff;
    assign shared_pin_oe        = pin_oe_ff;
    assign timer_irq            = tirq_ff;
    assign watchdog_timeout_irq = wdirq_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    a_reset_state: assert property (@(posedge aclk)
        !aresetn |=> !wd_en_ff && tim_ff == 16'hFFFF && prd_ff == 16'hFFFF && !prescale_mode_select_ff)
        else $error("reset state wrong");
    a_tmo_flag_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_tmo |=> wd_flag_ff && watchdog_timeout_irq)
        else $error("time-out did not raise flag and irq");
    a_tmo_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_tmo |=> wd_tim_ff == $past(wd_prd_ff))
        else $error("watchdog not reloaded after time-out");
    a_no_pulse_off: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_tmo && !wd_en_ff && pulse_ff == 4'h0 |=> pulse_ff == 4'h0)
        else $error("pulse while disabled");
    a_pulse_out: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_tmo && wd_en_ff |=> ##1 shared_pin_oe && shared_pin_o == WD_PULSE_LVL)
        else $error("enabled time-out gave no pin pulse");
    a_en_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_en_ff && !wd_tmo |=> wd_en_ff)
        else $error("watchdog disabled without time-out");
    a_tmo_disable: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_tmo |=> !wd_en_ff)
        else $error("time-out left watchdog enabled");
    a_wd_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !svc_hit && !w_tick |=> $stable(wd_tim_ff))
        else $error("watchdog count moved without tick or service");
    a_tim_step: assert property (@(posedge aclk) disable iff (!aresetn)
        t_tick && tim_ff != 16'h0000 && !sel_tim && !trb_pulse
        |=> tim_ff == $past(tim_ff) - 16'h0001)
        else $error("timer did not step on prescaler zero");
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top import ptw_pkg::*; ;
    // Bus, pin and event signals
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, gpio_pin_o, gpio_pin_oe;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, shared_pin_o, shared_pin_oe, timer_irq;
    logic        watchdog_timeout_irq;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] d;
    int          n_fail, tests_run, k, oes, lows;

    ptw_top u_ptw_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_pin_o,
        .gpio_pin_oe, .shared_pin_o, .shared_pin_oe, .timer_irq, .watchdog_timeout_irq);

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task final_report;
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One edge of a bounded wait; a hang ends the run
    task tick;
        @(posedge aclk);
        k++;
        if (k > 300) begin
            n_fail++;
            final_report;
        end
    endtask
    // Address and data offered together, each dropped once taken
    task wr(input logic [5:0] a, input logic [15:0] v, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
            tick;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        while (s_axi_arvalid || !s_axi_rvalid) begin
            tick;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        rv = s_axi_rdata;
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask
    task rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a, RESP_OKAY);
        chk(rv & m, e);
    endtask
    // Edges between two timer interrupts, both waits bounded
    task tper(input int e);
        k = 0;
        while (timer_irq !== 1'b1) tick;
        k = 0;
        tick;
        while (timer_irq !== 1'b1) tick;
        chk(k, e);
    endtask
    // Wait for a time-out, counting cycles the pin is driven meanwhile
    task wdog;
        k = 0;
        oes = 0;
        while (watchdog_timeout_irq !== 1'b1) begin
            tick;
            oes += (shared_pin_oe === 1'b1);
        end
    endtask

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, gpio_pin_oe, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        gpio_pin_o = 1'b1;
        s_axi_wstrb = 4'hF;
        n_fail = 0;
        tests_run = 0;
        k = $urandom(32'hFCBCA592);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rc(OFS_PRD, 32'hFFFF, 32'hFFFF);
        rd(OFS_TIM, RESP_OKAY);
        chk(rv[15:8] == 8'hFF && rv[7:0] != 8'hFF, 1);
        rc(OFS_TCR, 32'hFC3F, 32'h0);
        rc(OFS_TIMER_PRESCALE_MODE_CONTROL, 32'hFFFF, 32'h0);
        rc(OFS_WD_TCR, 32'hFC3F, 32'h000F);
        rc(OFS_WD_TIMER_PRESCALE_MODE_CONTROL, 32'hFFFF, 32'h0);
        rd(6'h3C, RESP_SLVERR);
        wr(6'h24, 16'h1234, RESP_SLVERR);
        // Random field writes, all ones first as the corner
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(OFS_TIMER_PRESCALE_MODE_CONTROL, d, RESP_OKAY);
            rc(OFS_TIMER_PRESCALE_MODE_CONTROL, 32'hFFFF, {16'h0000, d & 16'h1000});
            wr(OFS_TCR, d, RESP_OKAY);
            rc(OFS_TCR, 32'hFC3F, {16'h0000, d & 16'h0C1F});
        end
        // Timer period: (TIMER_RELOAD_PERIOD+1) ticks, each tick prescale+1 clocks
        wr(OFS_TIMER_PRESCALE_MODE_CONTROL, 16'h0000, RESP_OKAY);
        wr(OFS_PRD, 16'h0010, RESP_OKAY);
        wr(OFS_TCR, 16'h0020, RESP_OKAY);
        tper(17);
        wr(OFS_TIMER_PRESCALE_MODE_CONTROL, 16'h1000, RESP_OKAY);
        wr(OFS_TCR, 16'h0022, RESP_OKAY);
        tper(136);
        // Short watchdog period so time-outs come quickly
        wr(OFS_WD_PRD, 16'h0080, RESP_OKAY);
        wr(OFS_WD_TCR, 16'h0000, RESP_OKAY);
        wr(OFS_WD_KEY, KEY_SVC_A, RESP_OKAY);
        wr(OFS_WD_KEY, KEY_SVC_B, RESP_OKAY);
        rd(OFS_WD_TIM, RESP_OKAY);
        chk(rv > 32'h60 && rv <= 32'h80, 1);
        wr(OFS_WD_KEY, KEY_EN_A, RESP_OKAY);
        wr(OFS_WD_KEY, 16'h1234, RESP_OKAY);
        wr(OFS_WD_KEY, KEY_EN_B, RESP_OKAY);
        rc(OFS_WD_TIMER_PRESCALE_MODE_CONTROL, 32'h2, 32'h0);
        wdog;
        chk(oes, 0);
        rc(OFS_WD_TIMER_PRESCALE_MODE_CONTROL, 32'h3, 32'h1);
        wr(OFS_WD_TIMER_PRESCALE_MODE_CONTROL, 16'h0001, RESP_OKAY);
        wr(OFS_WD_KEY, KEY_EN_A, RESP_OKAY);
        wr(OFS_WD_KEY, KEY_EN_B, RESP_OKAY);
        rc(OFS_WD_TIMER_PRESCALE_MODE_CONTROL, 32'h3, 32'h2);
        chk(shared_pin_oe, 1);
        wr(OFS_WD_TIMER_PRESCALE_MODE_CONTROL, 16'h0000, RESP_OKAY);
        rc(OFS_WD_TIMER_PRESCALE_MODE_CONTROL, 32'h2, 32'h2);
        wdog;
        lows = 0;
        repeat (8) @(posedge aclk) lows += (shared_pin_o === 1'b0);
        chk(lows, 2);
        rc(OFS_WD_TIMER_PRESCALE_MODE_CONTROL, 32'h3, 32'h1);
        final_report;
    end
endmodule
`default_nettype wire
